// ==== inc/token_bus_pkg.sv ====
// Constants, register map and target rotation lookup for the token bus station.
package token_bus_pkg;

	localparam int unsigned CORE_CLK_HZ = 125_000_000;
	localparam int unsigned BAUD_9K6 = 9600;
	localparam int unsigned BAUD_19K2 = 19200;
	localparam int unsigned BAUD_187K5 = 187500;
	localparam int unsigned DIV_9K6 = CORE_CLK_HZ / BAUD_9K6;
	localparam int unsigned DIV_19K2 = CORE_CLK_HZ / BAUD_19K2;
	localparam int unsigned DIV_187K5 = CORE_CLK_HZ / BAUD_187K5;
	localparam int unsigned DIV_W = 14;

	localparam logic [1:0] BAUD_SEL_9K6 = 2'h0;
	localparam logic [1:0] BAUD_SEL_19K2 = 2'h1;
	localparam logic [1:0] BAUD_SEL_187K5 = 2'h2;

	localparam int unsigned ROT_W = 20;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LIMIT = 8'h04;
	localparam logic [7:0] REG_GAP = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_ROT = 8'h10;
	localparam logic [7:0] REG_TARGET = 8'h14;
	localparam logic [7:0] REG_CONN = 8'h18;

	localparam int unsigned CTRL_MASTER_EN_BIT = 0;
	localparam int unsigned CTRL_BAUD_LSB = 1;
	localparam int unsigned CTRL_CONN_PROTO_BIT = 3;
	localparam int unsigned STAT_HOLD_BIT = 0;
	localparam int unsigned STAT_SHARED0_BIT = 1;
	localparam int unsigned STAT_SHARED1_BIT = 2;
	localparam int unsigned STAT_LATE_BIT = 3;
	localparam int unsigned STAT_PROTO_BLK_BIT = 4;

	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [6:0] LIMIT_RESET = 7'h1F;
	localparam logic [7:0] GAP_RESET = 8'h0A;

	localparam logic [6:0] LIMIT_15 = 7'h0F;
	localparam logic [6:0] LIMIT_31 = 7'h1F;
	localparam logic [6:0] LIMIT_63 = 7'h3F;

	// Target rotation times in microseconds, rows by limit, columns by bit rate
	localparam longint TGT_US_15_9K6 = 613_000;
	localparam longint TGT_US_15_19K2 = 307_000;
	localparam longint TGT_US_15_187K5 = 31_000;
	localparam longint TGT_US_31_9K6 = 1_040_000;
	localparam longint TGT_US_31_19K2 = 520_000;
	localparam longint TGT_US_31_187K5 = 53_000;
	localparam longint TGT_US_63_9K6 = 1_890_000;
	localparam longint TGT_US_63_19K2 = 950_000;
	localparam longint TGT_US_63_187K5 = 97_000;
	localparam longint TGT_US_126_9K6 = 3_570_000;
	localparam longint TGT_US_126_19K2 = 1_790_000;
	localparam longint TGT_US_126_187K5 = 183_000;
	localparam longint US_PER_S = 1_000_000;

	localparam int unsigned PORTS = 2;
	localparam int unsigned CONN_PER_PORT = 4;
	localparam int unsigned CONN_TOTAL = PORTS * CONN_PER_PORT;
	localparam logic [1:0] CLS_PROG = 2'h0;
	localparam logic [1:0] CLS_PANEL = 2'h1;
	localparam logic [1:0] CLS_OTHER = 2'h2;
	localparam int unsigned SLOT_PROG = 0;
	localparam int unsigned SLOT_PANEL = 1;

	function automatic logic [ROT_W-1:0] target_bits(input logic [1:0] baud,
		input logic [6:0] limit);
		longint us;
		longint rate;
		// Both upper codes run at the fast rate, as the bit divider does
		if (baud == BAUD_SEL_9K6) begin
			rate = BAUD_9K6;
		end else if (baud == BAUD_SEL_19K2) begin
			rate = BAUD_19K2;
		end else begin
			rate = BAUD_187K5;
		end
		// Limits between table rows round up to the next row
		if (limit <= LIMIT_15) begin
			us = (rate == BAUD_9K6) ? TGT_US_15_9K6 :
				(rate == BAUD_19K2) ? TGT_US_15_19K2 : TGT_US_15_187K5;
		end else if (limit <= LIMIT_31) begin
			us = (rate == BAUD_9K6) ? TGT_US_31_9K6 :
				(rate == BAUD_19K2) ? TGT_US_31_19K2 : TGT_US_31_187K5;
		end else if (limit <= LIMIT_63) begin
			us = (rate == BAUD_9K6) ? TGT_US_63_9K6 :
				(rate == BAUD_19K2) ? TGT_US_63_19K2 : TGT_US_63_187K5;
		end else begin
			us = (rate == BAUD_9K6) ? TGT_US_126_9K6 :
				(rate == BAUD_19K2) ? TGT_US_126_19K2 : TGT_US_126_187K5;
		end
		target_bits = ROT_W'((us * rate) / US_PER_S);
	endfunction

endpackage

// ==== inc/conn_if.sv ====
// Lookup and update channel between the access controller and its connection table.
interface conn_if;
	logic port_sel;
	logic [6:0] src;
	logic [1:0] cls;
	logic open;
	logic close;
	logic hit;
	logic grant;
	logic [2:0] slot;
	logic [7:0] valid_map;

	modport table_side (
		input port_sel, src, cls, open, close,
		output hit, grant, slot, valid_map
	);
	modport user_side (
		output port_sel, src, cls, open, close,
		input hit, grant, slot, valid_map
	);
endinterface

// ==== design/conn_table.sv ====
// Table of connection-oriented links, four per serial port.
module conn_table
	import token_bus_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	conn_if.table_side cif
);

	logic [CONN_TOTAL-1:0] valid_ff;
	logic [6:0] owner_ff [CONN_TOTAL];
	logic [2:0] free_slot;
	logic free_ok;
	logic [2:0] hit_slot;

	function automatic logic slot_allowed(input logic [1:0] cls, input int unsigned s);
		if (s == SLOT_PROG) begin
			slot_allowed = (cls == CLS_PROG);
		end else if (s == SLOT_PANEL) begin
			slot_allowed = (cls == CLS_PANEL);
		end else begin
			slot_allowed = (cls == CLS_OTHER);
		end
	endfunction

	always_comb begin
		cif.hit = 1'b0;
		hit_slot = 3'h0;
		free_ok = 1'b0;
		free_slot = 3'h0;
		for (int s = 0; s < CONN_PER_PORT; s++) begin
			if (valid_ff[{cif.port_sel, 2'(s)}] && owner_ff[{cif.port_sel, 2'(s)}] == cif.src) begin
				cif.hit = 1'b1;
				hit_slot = {cif.port_sel, 2'(s)};
			end
			// Reserved slots stay closed to the wrong class of master
			if (!free_ok && !valid_ff[{cif.port_sel, 2'(s)}] && slot_allowed(cif.cls, s)) begin
				free_ok = 1'b1;
				free_slot = {cif.port_sel, 2'(s)};
			end
		end
		cif.grant = cif.hit || free_ok;
		cif.slot = cif.hit ? hit_slot : free_slot;
	end

	assign cif.valid_map = valid_ff;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			valid_ff <= '0;
		end else if (cif.close && cif.hit) begin
			valid_ff[cif.slot] <= 1'b0;
		end else if (cif.open && cif.grant && !cif.hit) begin
			valid_ff[cif.slot] <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			for (int i = 0; i < CONN_TOTAL; i++) begin
				owner_ff[i] <= 7'h00;
			end
		end else if (cif.open && cif.grant && !cif.hit) begin
			owner_ff[cif.slot] <= cif.src;
		end
	end

endmodule

// ==== design/token_bus_access_control.sv ====
// Token bus station: token hold, rotation timing, gap probing and connection control.
//
// Implementation choices: the plain strobed port and the register offsets.
module token_bus_access_control (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [token_bus_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [token_bus_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [token_bus_pkg::DATA_W-1:0] reg_rdata,
	input wire logic token_rx,
	input wire logic app_req_pending,
	input wire logic master_resp_done,
	input wire logic probe_done,
	output logic req_send,
	output logic req_skipped,
	output logic gap_probe,
	output logic [6:0] probe_limit,
	output logic token_pass,
	input wire logic slv_req,
	input wire logic slv_req_port,
	input wire logic [6:0] slv_req_src,
	input wire logic slv_req_conn,
	input wire logic [1:0] slv_req_cls,
	input wire logic slv_close,
	input wire logic slv_resp_done,
	input wire logic slv_resp_port,
	output logic slv_accept,
	output logic slv_reject,
	output logic [2:0] slv_slot
);
	import token_bus_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_HOLD = 5'h02,
		ST_WAIT_RESP = 5'h04,
		ST_PROBE = 5'h08,
		ST_PASS = 5'h10
	} master_state_t;

	master_state_t state_ff;
	master_state_t nxt_state;

	logic master_en_ff;
	logic [1:0] baud_ff;
	logic conn_proto_ff;
	logic [6:0] limit_ff;
	logic [7:0] gap_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [DIV_W-1:0] div_ff;
	logic [DIV_W-1:0] div_max;
	logic bit_tick;
	logic [ROT_W-1:0] rot_cnt_ff;
	logic [ROT_W-1:0] rot_last_ff;
	logic rot_run_ff;
	logic late_ff;
	logic [ROT_W-1:0] target;
	logic [7:0] hold_cnt_ff;
	logic req_send_ff;
	logic req_skip_ff;
	logic probe_ff;
	logic pass_ff;
	logic proto_blk;
	logic [PORTS-1:0] shared_busy_ff;
	logic accept_ff;
	logic reject_ff;
	logic [2:0] slot_ff;
	logic shared_ok;
	logic conn_ok;
	logic probe_due;

	conn_if cif ();

	conn_table u_conn_table (
		.core_clk(core_clk),
		.rstn(rstn),
		.cif(cif)
	);

	// Register writes
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			master_en_ff <= CTRL_RESET[CTRL_MASTER_EN_BIT];
			baud_ff <= CTRL_RESET[CTRL_BAUD_LSB +: 2];
			conn_proto_ff <= CTRL_RESET[CTRL_CONN_PROTO_BIT];
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			master_en_ff <= reg_wdata[CTRL_MASTER_EN_BIT];
			baud_ff <= reg_wdata[CTRL_BAUD_LSB +: 2];
			conn_proto_ff <= reg_wdata[CTRL_CONN_PROTO_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			limit_ff <= LIMIT_RESET;
			gap_ff <= GAP_RESET;
		end else if (reg_wr) begin
			if (reg_addr == REG_LIMIT) begin
				limit_ff <= reg_wdata[6:0];
			end
			// Zero would probe at every hold, as one does, so it is stored as one
			if (reg_addr == REG_GAP) begin
				gap_ff <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
			end
		end
	end

	// Register reads, data in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rdata_ff <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: rdata_ff <= DATA_W'({conn_proto_ff, baud_ff, master_en_ff});
				REG_LIMIT: rdata_ff <= DATA_W'(limit_ff);
				REG_GAP: rdata_ff <= DATA_W'(gap_ff);
				REG_STATUS: rdata_ff <= DATA_W'({proto_blk, late_ff, shared_busy_ff,
					state_ff != ST_IDLE});
				REG_ROT: rdata_ff <= DATA_W'(rot_last_ff);
				REG_TARGET: rdata_ff <= DATA_W'(target);
				REG_CONN: rdata_ff <= DATA_W'(cif.valid_map);
				default: rdata_ff <= '0;
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	assign reg_rdata = rdata_ff;

	// Bit-time divider; rates other than the two slow ones count as the fast one
	always_comb begin
		case (baud_ff)
			BAUD_SEL_9K6: div_max = DIV_W'(DIV_9K6 - 1);
			BAUD_SEL_19K2: div_max = DIV_W'(DIV_19K2 - 1);
			default: div_max = DIV_W'(DIV_187K5 - 1);
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			div_ff <= '0;
		end else if (div_ff >= div_max) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	assign bit_tick = (div_ff >= div_max);

	assign target = target_bits(baud_ff, limit_ff);

	// Rotation counter, restarted at each pass and saturating
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rot_cnt_ff <= '0;
			rot_run_ff <= 1'b0;
		end else if (pass_ff) begin
			rot_cnt_ff <= '0;
			rot_run_ff <= 1'b1;
		end else if (token_rx && state_ff == ST_IDLE) begin
			rot_run_ff <= 1'b0;
		end else if (rot_run_ff && bit_tick && rot_cnt_ff != '1) begin
			rot_cnt_ff <= rot_cnt_ff + 1'b1;
		end
	end

	// Sample at arrival; the first token after reset has no history and is on time
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rot_last_ff <= '0;
			late_ff <= 1'b0;
		end else if (token_rx && state_ff == ST_IDLE && master_en_ff) begin
			rot_last_ff <= rot_run_ff ? rot_cnt_ff : '0;
			late_ff <= rot_run_ff && (rot_cnt_ff >= target);
		end
	end

	// Connection protocols are slave only; the master sends on the shared link alone
	assign proto_blk = master_en_ff && conn_proto_ff;

	assign probe_due = (hold_cnt_ff >= gap_ff);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (token_rx && master_en_ff) begin
					nxt_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// Only the two slow rates wait out the response
				if (app_req_pending && !late_ff && !proto_blk &&
					(baud_ff == BAUD_SEL_9K6 || baud_ff == BAUD_SEL_19K2)) begin
					nxt_state = ST_WAIT_RESP;
				end else if (probe_due) begin
					nxt_state = ST_PROBE;
				end else begin
					nxt_state = ST_PASS;
				end
			end
			ST_WAIT_RESP: begin
				if (master_resp_done) begin
					nxt_state = probe_due ? ST_PROBE : ST_PASS;
				end
			end
			ST_PROBE: begin
				if (probe_done) begin
					nxt_state = ST_PASS;
				end
			end
			ST_PASS: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Holds since the last probe, counted as each hold starts; saturates
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hold_cnt_ff <= 8'h00;
		end else if (state_ff == ST_PROBE && probe_done) begin
			hold_cnt_ff <= 8'h00;
		end else if (state_ff == ST_IDLE && nxt_state == ST_HOLD && hold_cnt_ff != 8'hFF) begin
			hold_cnt_ff <= hold_cnt_ff + 8'h01;
		end
	end

	// Master pulses, one cycle each
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			req_send_ff <= 1'b0;
			req_skip_ff <= 1'b0;
			probe_ff <= 1'b0;
			pass_ff <= 1'b0;
		end else begin
			req_send_ff <= state_ff == ST_HOLD && app_req_pending && !late_ff && !proto_blk;
			req_skip_ff <= state_ff == ST_HOLD && app_req_pending && (late_ff || proto_blk);
			probe_ff <= state_ff != ST_PROBE && nxt_state == ST_PROBE;
			pass_ff <= state_ff == ST_PASS;
		end
	end

	assign req_send = req_send_ff;
	assign req_skipped = req_skip_ff;
	assign gap_probe = probe_ff;
	assign token_pass = pass_ff;
	assign probe_limit = limit_ff;

	// Slave side: shared connection per port or connection-oriented table
	assign cif.port_sel = slv_req_port;
	assign cif.src = slv_req_src;
	assign cif.cls = slv_req_cls;
	assign cif.open = slv_req && slv_req_conn;
	assign cif.close = slv_close;

	assign shared_ok = !shared_busy_ff[slv_req_port];
	assign conn_ok = cif.grant;

	generate
		for (genvar p = 0; p < PORTS; p++) begin : g_shared
			// Accepting a request wins over a response ending in the same cycle
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					shared_busy_ff[p] <= 1'b0;
				end else if (slv_req && !slv_req_conn && slv_req_port == p && shared_ok) begin
					shared_busy_ff[p] <= 1'b1;
				end else if (slv_resp_done && slv_resp_port == p) begin
					shared_busy_ff[p] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			accept_ff <= 1'b0;
			reject_ff <= 1'b0;
			slot_ff <= 3'h0;
		end else begin
			accept_ff <= slv_req && (slv_req_conn ? conn_ok : shared_ok);
			reject_ff <= slv_req && !(slv_req_conn ? conn_ok : shared_ok);
			if (slv_req && slv_req_conn) begin
				slot_ff <= cif.slot;
			end
		end
	end

	assign slv_accept = accept_ff;
	assign slv_reject = reject_ff;
	assign slv_slot = slot_ff;

endmodule

// ==== verif/token_bus_access_control_properties.sv ====
// Port-level assertions for the token bus station.
module token_bus_access_control_checker
	import token_bus_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [token_bus_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [token_bus_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic master_resp_done,
	input wire logic req_send,
	input wire logic gap_probe,
	input wire logic [6:0] probe_limit,
	input wire logic token_pass,
	input wire logic slv_req,
	input wire logic slv_req_port,
	input wire logic slv_req_conn,
	input wire logic [1:0] slv_req_cls,
	input wire logic slv_resp_done,
	input wire logic slv_resp_port,
	input wire logic slv_accept,
	input wire logic slv_reject,
	input wire logic [2:0] slv_slot
);
	logic [3:0] ctrl_ff;
	logic [1:0] busy_ff;
	logic sh_ff;
	logic port_ff;
	logic wait_ff;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ctrl_ff <= CTRL_RESET;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			ctrl_ff <= reg_wdata[3:0];
		end
	end
	// Slow master owes a response before the token moves
	always_ff @(posedge core_clk) begin
		if (!rstn || master_resp_done) begin
			wait_ff <= 1'b0;
		end else if (req_send && !ctrl_ff[2]) begin
			wait_ff <= 1'b1;
		end
	end
	// Set a cycle late, so never stricter than the station
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			busy_ff <= 2'h0;
			sh_ff <= 1'b0;
			port_ff <= 1'b0;
		end else begin
			sh_ff <= slv_req && !slv_req_conn;
			port_ff <= slv_req_port;
			for (int p = 0; p < 2; p++) begin
				// A response right after the accept has already ended it
				if (slv_resp_done && slv_resp_port == 1'(p)) begin
					busy_ff[p] <= 1'b0;
				end else if (sh_ff && slv_accept && port_ff == 1'(p)) begin
					busy_ff[p] <= 1'b1;
				end
			end
		end
	end
	send_pass_a: assert property (req_send && ctrl_ff[2] && !gap_probe
		|=> token_pass || gap_probe) else $error("fast request kept token");
	slow_hold_a: assert property (wait_ff |-> !token_pass)
		else $error("token passed before response");
	slow_release_a: assert property (wait_ff && master_resp_done
		|-> ##[1:2] (gap_probe || token_pass)) else $error("token held after response");
	slave_answer_a: assert property (slv_req |=> slv_accept != slv_reject)
		else $error("request not answered once");
	shared_busy_a: assert property (slv_req && !slv_req_conn && busy_ff[slv_req_port]
		&& !(slv_resp_done && slv_resp_port == slv_req_port) |=> slv_reject)
		else $error("busy shared link accepted");
	reserve_slot_a: assert property (slv_req && slv_req_conn && slv_req_cls == CLS_OTHER
		|=> !slv_accept || slv_slot[1]) else $error("reserved slot taken");
	class_slot_a: assert property (slv_req && slv_req_conn && slv_req_cls != CLS_OTHER
		|=> !slv_accept || slv_slot[1:0] == {1'b0, $past(slv_req_cls[0])})
		else $error("reserved class in wrong slot");
	port_slot_a: assert property (slv_req && slv_req_conn
		|=> !slv_accept || slv_slot[2] == $past(slv_req_port)) else $error("slot on wrong port");
	limit_follow_a: assert property (reg_wr && reg_addr == REG_LIMIT
		|=> probe_limit == $past(reg_wdata[6:0])) else $error("probe limit stale");
	proto_block_a: assert property (ctrl_ff[0] && ctrl_ff[3] |=> !req_send)
		else $error("request sent under connection protocol");
	cover property (req_send && ctrl_ff[2]);
	cover property (wait_ff && master_resp_done);
	cover property (gap_probe);
	cover property (slv_reject);
endmodule
bind token_bus_access_control token_bus_access_control_checker chk_u (.core_clk, .rstn,
	.reg_addr, .reg_wdata, .reg_wr, .master_resp_done, .req_send, .gap_probe, .probe_limit,
	.token_pass, .slv_req, .slv_req_port, .slv_req_conn, .slv_req_cls, .slv_resp_done,
	.slv_resp_port, .slv_accept, .slv_reject, .slv_slot);

// ==== verif/token_bus_peer_model.sv ====
// Peer stations: return the token, answer requests, finish gap probes.
module token_bus_peer_model (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic kick,
	input wire logic slow,
	input wire logic [15:0] tok_gap,
	input wire logic token_pass,
	input wire logic req_send,
	input wire logic gap_probe,
	output logic token_rx,
	output logic master_resp_done,
	output logic probe_done
);
	logic [15:0] tok_ff = '0;
	logic [7:0] resp_ff = '0;
	logic [7:0] probe_ff = '0;
	// Peers share one limit and short gap checks; ring far under target
	always @(posedge core_clk) begin
		token_rx <= 1'b0;
		master_resp_done <= 1'b0;
		probe_done <= 1'b0;
		if (!rstn) begin
			tok_ff <= '0;
			resp_ff <= '0;
			probe_ff <= '0;
		end else begin
			// Zero gap parks the token so the ring stops between scenarios
			if ((token_pass || kick) && tok_gap != 0) begin
				tok_ff <= tok_gap;
			end else if (tok_ff != 0) begin
				tok_ff <= tok_ff - 1'b1;
				token_rx <= tok_ff == 16'h1 && tok_gap != 0;
			end
			if (req_send && slow) begin
				resp_ff <= 8'h28;
			end else if (resp_ff != 0) begin
				resp_ff <= resp_ff - 1'b1;
				master_resp_done <= resp_ff == 8'h1;
			end
			if (gap_probe) begin
				probe_ff <= 8'h0A;
			end else if (probe_ff != 0) begin
				probe_ff <= probe_ff - 1'b1;
				probe_done <= probe_ff == 8'h1;
			end
		end
	end
endmodule

// ==== verif/token_bus_access_control_tb.sv ====
// Self-checking bench for the token bus station.
module token_bus_access_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import token_bus_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic [DATA_W-1:0] reg_rdata, rd_v;
	logic reg_wr = 1'b0, reg_rd = 1'b0, app_req_pending = 1'b0, kick = 1'b0, slow = 1'b0;
	logic slv_req = 1'b0, slv_req_port = 1'b0, slv_req_conn = 1'b0, slv_close = 1'b0;
	logic slv_resp_done = 1'b0, slv_resp_port = 1'b0;
	logic [6:0] slv_req_src = '0;
	logic [1:0] slv_req_cls = '0;
	logic [15:0] tok_gap = '0;
	logic token_rx, master_resp_done, probe_done, req_send, req_skipped, gap_probe, token_pass;
	logic slv_accept, slv_reject;
	logic [6:0] probe_limit;
	logic [2:0] slv_slot;
	int num_errors = 0, n_checks = 0, n_send = 0, n_skip = 0, n_probe = 0, n_pass = 0;
	int lims[4] = '{15, 31, 63, 126};
	token_bus_access_control dut_u (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .token_rx, .app_req_pending, .master_resp_done, .probe_done, .req_send,
		.req_skipped, .gap_probe, .probe_limit, .token_pass, .slv_req, .slv_req_port,
		.slv_req_src, .slv_req_conn, .slv_req_cls, .slv_close, .slv_resp_done,
		.slv_resp_port, .slv_accept, .slv_reject, .slv_slot);
	token_bus_peer_model peer_u (.core_clk, .rstn, .kick, .slow, .tok_gap, .token_pass,
		.req_send, .gap_probe, .token_rx, .master_resp_done, .probe_done);
	initial forever #4 core_clk = ~core_clk;
	// Kick opens a scenario, so the tallies restart there
	always @(posedge core_clk) begin
		if (kick) begin
			n_send <= 0;
			n_skip <= 0;
			n_probe <= 0;
			n_pass <= 0;
		end else begin
			n_send <= n_send + int'(req_send === 1'b1);
			n_skip <= n_skip + int'(req_skipped === 1'b1);
			n_probe <= n_probe + int'(gap_probe === 1'b1);
			n_pass <= n_pass + int'(token_pass === 1'b1);
		end
	end
	task results();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rc(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
		check(what, rd_v, exp);
	endtask
	task slv(input int p, input int s, input int c, input int k, input int acc, input int slot);
		@(posedge core_clk);
		slv_req <= 1'b1;
		slv_req_port <= 1'(p);
		slv_req_src <= 7'(s);
		slv_req_conn <= 1'(c);
		slv_req_cls <= 2'(k);
		@(posedge core_clk);
		slv_req <= 1'b0;
		#1 check("accept", slv_accept, 32'(acc));
		check("reject", slv_reject, 32'(acc == 0));
		if (acc != 0 && c != 0) check("slot", slv_slot, 32'(slot));
	endtask
	task ev(input int close, input int p, input int s);
		@(posedge core_clk);
		slv_close <= 1'(close);
		slv_resp_done <= 1'(close == 0);
		slv_resp_port <= 1'(p);
		slv_req_port <= 1'(p);
		slv_req_src <= 7'(s);
		@(posedge core_clk);
		slv_close <= 1'b0;
		slv_resp_done <= 1'b0;
	endtask
	// Runs n token holds; a stalled ring ends the run
	task holds(input int n);
		#1;
		tok_gap = 16'd2000;
		@(posedge core_clk);
		kick <= 1'b1;
		@(posedge core_clk);
		kick <= 1'b0;
		#1;
		for (int i = 0; i < 30000 * n && n_pass < n; i++) @(posedge core_clk);
		tok_gap <= '0;
		#1;
		if (n_pass < n) begin
			num_errors++;
			$display("ERROR ring expected %0d seen %0d", n, n_pass);
			results();
		end
	endtask
	function automatic logic [31:0] tgt(input int b, input int l);
		longint us[3][4] = '{'{613000, 1040000, 1890000, 3570000},
			'{307000, 520000, 950000, 1790000}, '{31000, 53000, 97000, 183000}};
		longint rt[3] = '{9600, 19200, 187500};
		int r;
		r = (b > 2) ? 2 : b;
		return 32'(us[r][l] * rt[r] / 64'd1000000);
	endfunction
	initial begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		rc("limit", REG_LIMIT, 32'h1F);
		rc("gap", REG_GAP, 32'h0A);
		check("probe_limit", probe_limit, 32'h1F);
		rc("ctrl", REG_CTRL, 32'h0);
		rc("unmapped", 8'h3C, 32'h0);
		for (int b = 0; b < 4; b++) begin
			for (int l = 0; l < 4; l++) begin
				wr(REG_CTRL, 32'(b) << 1);
				wr(REG_LIMIT, 32'(lims[l]));
				rc("target", REG_TARGET, tgt(b, l));
			end
		end
		check("probe_limit", probe_limit, 32'h7E);
		wr(REG_GAP, 32'h0);
		rc("gap", REG_GAP, 32'h1);
		wr(REG_GAP, 32'hA);
		app_req_pending <= 1'b1;
		wr(REG_CTRL, 32'h5);
		holds(4);
		check("send", n_send, 4);
		check("probe", n_probe, 0);
		rc("status", REG_STATUS, 32'h0);
		check("pass", n_pass, 4);
		@(posedge core_clk);
		reg_addr <= REG_ROT;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 check("rot", 32'(reg_rdata >= 2 && reg_rdata <= 4), 1);
		wr(REG_GAP, 32'h2);
		holds(4);
		check("probe", n_probe, 2);
		wr(REG_GAP, 32'h1);
		holds(3);
		check("probe", n_probe, 3);
		wr(REG_GAP, 32'hA);
		wr(REG_CTRL, 32'hD);
		holds(2);
		check("skip", n_skip, 2);
		check("send", n_send, 0);
		wr(REG_CTRL, 32'h1);
		slow <= 1'b1;
		holds(3);
		check("send", n_send, 3);
		app_req_pending <= 1'b0;
		holds(2);
		check("idle", n_send + n_skip, 0);
		slv(0, 5, 0, CLS_OTHER, 1, 0);
		slv(0, 6, 0, CLS_OTHER, 0, 0);
		slv(1, 6, 0, CLS_OTHER, 1, 0);
		rc("status", REG_STATUS, 32'h6);
		ev(0, 0, 0);
		slv(0, 6, 0, CLS_OTHER, 1, 0);
		slv(0, 10, 1, CLS_PROG, 1, 0);
		slv(0, 11, 1, CLS_PANEL, 1, 1);
		slv(0, 12, 1, CLS_OTHER, 1, 2);
		slv(0, 13, 1, CLS_OTHER, 1, 3);
		slv(0, 14, 1, CLS_OTHER, 0, 0);
		slv(0, 15, 1, CLS_PROG, 0, 0);
		slv(0, 12, 1, CLS_OTHER, 1, 2);
		slv(1, 20, 1, CLS_OTHER, 1, 6);
		slv(1, 21, 1, CLS_OTHER, 1, 7);
		slv(1, 22, 1, CLS_OTHER, 0, 0);
		slv(1, 23, 1, 3, 0, 0);
		slv(1, 24, 1, CLS_PANEL, 1, 5);
		rc("conn", REG_CONN, 32'hEF);
		ev(1, 0, 12);
		rc("conn", REG_CONN, 32'hEB);
		slv(0, 14, 1, CLS_OTHER, 1, 2);
		results();
	end
endmodule
